// ---- src/hpa_pkg.sv ----
package hpa_pkg;
	// seven-bit slave address
	localparam logic [6:0] HPA_SLAVE_ADDR   = 7'h60;
	// register numbers
	localparam logic [7:0] HPA_REG_CTRL     = 8'h01;
	localparam logic [7:0] HPA_REG_VOL      = 8'h02;
	localparam logic [7:0] HPA_REG_IMP      = 8'h03;
	localparam logic [7:0] HPA_REG_REV      = 8'h04;
	// field positions in amp_control
	localparam int         HPA_CTRL_EN_L    = 7;
	localparam int         HPA_CTRL_EN_R    = 6;
	localparam int         HPA_CTRL_MODE_HI = 5;
	localparam int         HPA_CTRL_MODE_LO = 4;
	localparam int         HPA_CTRL_THERM   = 1;
	localparam int         HPA_CTRL_PDOWN   = 0;
	// field positions in mute_and_volume
	localparam int         HPA_VOL_MUTE_L   = 7;
	localparam int         HPA_VOL_MUTE_R   = 6;
	// field positions in output_impedance
	localparam int         HPA_IMP_FLOAT_L  = 1;
	localparam int         HPA_IMP_FLOAT_R  = 0;
	// reset values
	localparam logic [7:0] HPA_CTRL_RST     = 8'h00;
	localparam logic [7:0] HPA_VOL_RST      = 8'hC0;
	localparam logic [7:0] HPA_IMP_RST      = 8'h00;
	// writable masks
	localparam logic [7:0] HPA_CTRL_WMASK   = 8'hF1;
	localparam logic [7:0] HPA_IMP_WMASK    = 8'h03;
	// output modes
	localparam logic [1:0] HPA_MODE_STEREO  = 2'h0;
	localparam logic [1:0] HPA_MODE_DMONO   = 2'h1;
	localparam logic [1:0] HPA_MODE_BTL     = 2'h2;
	// bits per byte on the wire
	localparam int         HPA_BYTE_BITS    = 8;
endpackage

// ---- src/hpa_sync.sv ----
`timescale 1ns/10ps
// two-flop synchroniser for one level from outside the clock domain
module hpa_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_q;	// first stage, read only by second stage
	// idle bus level is high, so reset to one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= 1'b1;
			sync_out <= 1'b1;
		end else if (ce) begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ---- src/hpa_bitcond.sv ----
`timescale 1ns/10ps
// edge and start/stop detector on synchronised bus lines
module hpa_bitcond (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic scl_s,
	input  wire logic sda_s,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_det,
	output logic      stop_det
);
	logic scl_prev_q;	// previous clock level
	logic sda_prev_q;	// previous data level
	// delay stage for edge finding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (ce) begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end
	// edge and condition decode
	assign scl_rise  = ce & scl_s & ~scl_prev_q;
	assign scl_fall  = ce & ~scl_s & scl_prev_q;
	// data falling while clock high is start, rising is stop
	assign start_det = ce & scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = ce & scl_s & scl_prev_q & ~sda_prev_q & sda_s;
endmodule

// ---- src/hpa_ctrl.sv ----
`timescale 1ns/10ps
module hpa_ctrl
	import hpa_pkg::*;
#(
	parameter logic [3:0] REVISION = 4'h1	// arbitrary silicon revision
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       thermal_event,
	input  wire logic [7:0] factory_test_bits,
	output logic            left_amp_enable,
	output logic            right_amp_enable,
	output logic [1:0]      output_mode,
	output logic            soft_powerdown,
	output logic            left_mute,
	output logic            right_mute,
	output logic [5:0]      volume,
	output logic            left_output_float,
	output logic            right_output_float
);
	// protocol phases
	typedef enum logic [2:0] {
		HPA_IDLE, HPA_ADDR, HPA_REGNUM, HPA_WDATA, HPA_RDATA
	} hpa_state_type;

	logic          scl_s;	// synchronised clock line
	logic          sda_s;	// synchronised data line
	logic          therm_s;	// synchronised thermal level
	logic          therm_prev_q;	// previous thermal level
	logic          scl_rise;	// sampling edge
	logic          scl_fall;	// drive edge
	logic          start_det;	// start or repeated start
	logic          stop_det;	// stop condition
	hpa_state_type state_q;	// protocol phase
	logic [7:0]    shift_q;	// receive shift register
	logic [3:0]    bitcnt_q;	// rises counted, ninth fall clears
	logic          rd_q;	// direction of the current frame
	logic [7:0]    ptr_q;	// register pointer
	logic [7:0]    tx_q;	// transmit shift register
	logic          ack_q;	// holding data low for ack
	logic          drv_q;	// driving a read data bit low
	logic          nak_q;	// master refused a read byte
	logic [7:0]    ctrl_q;	// amp_control
	logic [7:0]    vol_q;	// mute_and_volume
	logic [7:0]    imp_q;	// output_impedance
	logic          sda_oe_q;	// registered pin enable
	logic          addr_hit_q;	// address match of the last byte

	// crossing from pins and the thermal sensor
	hpa_sync u_sync_scl (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (scl_in),
		.sync_out (scl_s)
	);
	hpa_sync u_sync_sda (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (sda_in),
		.sync_out (sda_s)
	);
	hpa_sync u_sync_th (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (thermal_event),
		.sync_out (therm_s)
	);
	hpa_bitcond u_cond (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.scl_s     (scl_s),
		.sda_s     (sda_s),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// read view of a register, reserved bits zero
	function automatic logic [7:0] hpa_read(
		input logic [7:0] idx,
		input logic [7:0] c,
		input logic [7:0] v,
		input logic [7:0] z,
		input logic [7:0] ft
	);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			HPA_REG_CTRL: r = c & HPA_CTRL_WMASK | (c & 8'h02);
			HPA_REG_VOL:  r = v;
			HPA_REG_IMP:  r = z & HPA_IMP_WMASK;
			HPA_REG_REV:  r = {2'b00, ft[5:4], REVISION};
			8'h05, 8'h06, 8'h07, 8'h08: r = ft;
			default:      r = 8'h00;
		endcase
		return r;
	endfunction

	// decoded bus events: eighth rise, ninth rise, ninth fall
	wire        byte_done  = scl_rise &
	                         (bitcnt_q == 4'(HPA_BYTE_BITS - 1));
	wire [7:0]  rx_byte    = {shift_q[6:0], sda_s};
	wire        addr_hit   = (rx_byte[7:1] == HPA_SLAVE_ADDR);
	wire        ack_slot   = (bitcnt_q == 4'(HPA_BYTE_BITS));
	// the ninth fall closes the acknowledge clock
	wire        ack_end    = scl_fall &
	                         (bitcnt_q == 4'(HPA_BYTE_BITS + 1));
	wire        rx_phase   = (state_q == HPA_ADDR) |
	                         (state_q == HPA_REGNUM) |
	                         (state_q == HPA_WDATA);
	wire        wr_strobe  = byte_done & (state_q == HPA_WDATA);
	wire [7:0]  rd_value   = hpa_read(ptr_q, ctrl_q, vol_q, imp_q,
	                                  factory_test_bits);
	wire        therm_rise = therm_s & ~therm_prev_q;
	// a byte is loaded for transmit at the fall ending an ack slot
	wire        tx_load    = ack_end & rd_q &
	                         ((state_q == HPA_ADDR) |
	                          (state_q == HPA_RDATA)) & ~nak_q;
	wire        read_ctrl  = tx_load & (ptr_q == HPA_REG_CTRL);
	// amp_control after a bus write, read-only bits kept
	wire        wr_ctrl    = wr_strobe & (ptr_q == HPA_REG_CTRL);
	wire [7:0]  ctrl_wr    = wr_ctrl ? ((rx_byte & HPA_CTRL_WMASK) |
	                         (ctrl_q & ~HPA_CTRL_WMASK)) : ctrl_q;

	// bit counter and receive shifting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitcnt_q <= 4'h0;
			shift_q  <= 8'h00;
		end else if (ce) begin
			if (start_det) begin
				bitcnt_q <= 4'h0;
			end else if (ack_end) begin
				bitcnt_q <= 4'h0;	// after ack, next byte
			end else if (scl_rise) begin
				shift_q  <= rx_byte;
				bitcnt_q <= bitcnt_q + 4'h1;
			end
		end
	end

	// protocol sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= HPA_IDLE;
			rd_q    <= 1'b0;
			nak_q   <= 1'b0;
		end else if (ce) begin
			if (start_det) begin
				state_q <= HPA_ADDR;	// also ends any write
				nak_q   <= 1'b0;
			end else if (stop_det) begin
				state_q <= HPA_IDLE;
			end else begin
				case (state_q)
					HPA_ADDR: begin
						if (byte_done) begin
							rd_q <= rx_byte[0];
							if (!addr_hit) begin
								state_q <= HPA_IDLE;
							end
						end else if (ack_end) begin
							state_q <= rd_q ? HPA_RDATA : HPA_REGNUM;
						end
					end
					HPA_REGNUM: begin
						if (ack_end) begin
							state_q <= HPA_WDATA;
						end
					end
					HPA_RDATA: begin
						// master ack sampled on ninth rise
						if (scl_rise & ack_slot & sda_s) begin
							nak_q <= 1'b1;
						end else if (nak_q & ack_end) begin
							state_q <= HPA_IDLE;
						end
					end
					HPA_WDATA: state_q <= HPA_WDATA;
					default:   state_q <= HPA_IDLE;
				endcase
			end
		end
	end

	// register pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= 8'h00;
		end else if (ce) begin
			if (byte_done & (state_q == HPA_REGNUM)) begin
				ptr_q <= rx_byte;
			end else if (wr_strobe) begin
				ptr_q <= ptr_q + 8'h01;
			end else if (tx_load) begin
				// every loaded byte moves on, the first one too
				ptr_q <= ptr_q + 8'h01;
			end
		end
	end

	// data line drive: acks and read bits, only ever low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			drv_q <= 1'b0;
			tx_q  <= 8'h00;
		end else if (ce) begin
			if (start_det | stop_det) begin
				ack_q <= 1'b0;
				drv_q <= 1'b0;
			end else if (scl_fall) begin
				// change only on falling clock
				ack_q <= ack_slot & rx_phase &
				         ~((state_q == HPA_ADDR) & ~addr_hit_q);
				// ninth fall: ack ends, first read bit starts
				if (tx_load) begin
					tx_q  <= {rd_value[6:0], 1'b0};
					drv_q <= ~rd_value[7];
				end else if ((state_q == HPA_RDATA) &
				             (bitcnt_q < 4'(HPA_BYTE_BITS)) & ~nak_q) begin
					// bits six to zero on falls one to seven
					tx_q  <= {tx_q[6:0], 1'b0};
					drv_q <= ~tx_q[7];
				end else begin
					drv_q <= 1'b0;	// release for master ack
				end
			end
		end
	end

	// address match held from the eighth rise to the ack
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_hit_q <= 1'b0;
		end else if (ce & byte_done) begin
			addr_hit_q <= addr_hit;
		end
	end

	// thermal edge finder
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			therm_prev_q <= 1'b1;	// as the synchroniser, no false edge
		end else if (ce) begin
			therm_prev_q <= therm_s;
		end
	end

	// amp_control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= HPA_CTRL_RST;
		end else if (ce) begin
			// bus write lands first, the overrides follow
			ctrl_q <= ctrl_wr;
			// powerdown forces enables off, a written value counts
			if (ctrl_wr[HPA_CTRL_PDOWN]) begin
				ctrl_q[HPA_CTRL_EN_L] <= 1'b0;
				ctrl_q[HPA_CTRL_EN_R] <= 1'b0;
			end
			// read clears, a new event wins
			if (therm_rise) begin
				ctrl_q[HPA_CTRL_THERM] <= 1'b1;
			end else if (read_ctrl) begin
				ctrl_q[HPA_CTRL_THERM] <= 1'b0;
			end
		end
	end

	// mute_and_volume and output_impedance registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vol_q <= HPA_VOL_RST;
			imp_q <= HPA_IMP_RST;
		end else if (ce & wr_strobe) begin
			if (ptr_q == HPA_REG_VOL) begin
				vol_q <= rx_byte;
			end
			if (ptr_q == HPA_REG_IMP) begin
				imp_q <= rx_byte & HPA_IMP_WMASK;
			end
		end
	end

	// registered pin enable, active low while pulling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_q <= 1'b1;
		end else if (ce) begin
			sda_oe_q <= ~(ack_q | drv_q);
		end
	end

	// outputs
	assign sda_out            = 1'b0;
	assign sda_oe             = sda_oe_q;
	assign left_amp_enable    = ctrl_q[HPA_CTRL_EN_L];
	assign right_amp_enable   = ctrl_q[HPA_CTRL_EN_R];
	assign output_mode        = ctrl_q[HPA_CTRL_MODE_HI:HPA_CTRL_MODE_LO];
	assign soft_powerdown     = ctrl_q[HPA_CTRL_PDOWN];
	assign left_mute          = vol_q[HPA_VOL_MUTE_L];
	assign right_mute         = vol_q[HPA_VOL_MUTE_R];
	assign volume             = vol_q[5:0];
	assign left_output_float  = imp_q[HPA_IMP_FLOAT_L];
	assign right_output_float = imp_q[HPA_IMP_FLOAT_R];
endmodule

// ---- tb/hpa_master.sv ----
`timescale 1ns/10ps
// bus master model: drives scl, pulls or releases sda
module hpa_master (
	input  wire logic       clk,
	input  wire logic       sda,
	output logic            scl,
	output logic            sda_m,
	output logic            ack_stb,
	output logic            ack_bit,
	output logic            byte_stb,
	output logic [7:0]      rd_byte
);
	// idle bus: clock stands high, data released to pull-up
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		ack_stb = 1'b0;
		ack_bit = 1'b0;
		byte_stb = 1'b0;
		rd_byte = 8'h00;
	end
	// quarter of the 80 ns bus clock, just after a clk edge
	task automatic q();
		repeat (5) @(posedge clk);
		#1;
	endtask
	// one bit out, data set mid-way through clock low
	task automatic put(input logic b);
		q();
		sda_m = b;
		q();
		scl = 1'b1;
		q();
		q();
		scl = 1'b0;
	endtask
	// one bit in, line released
	task automatic get(output logic b);
		q();
		sda_m = 1'b1;
		q();
		scl = 1'b1;
		q();
		b = sda;
		q();
		scl = 1'b0;
	endtask
	// start or repeated start: data falls, clock high
	task automatic start();
		q();
		sda_m = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_m = 1'b0;
		q();
		scl = 1'b0;
	endtask
	// stop: data rises, clock high
	task automatic stop();
		q();
		sda_m = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_m = 1'b1;
		q();
	endtask
	// byte out msb first, ack bit reported
	task automatic wr(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) put(d[i]);
		get(a);
		ack_bit = a;
		ack_stb = 1'b1;
		#1 ack_stb = 1'b0;
	endtask
	// byte in msb first, nak only on the last
	task automatic rd(input logic last);
		logic [7:0] d;
		logic       b;
		for (int i = 0; i < 8; i++) begin
			get(b);
			d = {d[6:0], b};
		end
		put(last);
		rd_byte = d;
		byte_stb = 1'b1;
		#1 byte_stb = 1'b0;
	endtask
endmodule

// ---- tb/hpa_ctrl_assertions.sv ----
`timescale 1ns/10ps
// port checks of the serial slave and register outputs
module hpa_ctrl_chk (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       left_amp_enable,
	input wire logic       right_amp_enable,
	input wire logic [1:0] output_mode,
	input wire logic       soft_powerdown,
	input wire logic       left_mute,
	input wire logic       right_mute,
	input wire logic [5:0] volume,
	input wire logic       left_output_float,
	input wire logic       right_output_float
);
	// all register outputs as one word
	wire logic [14:0] outs = {left_amp_enable, right_amp_enable, output_mode,
		soft_powerdown, left_mute, right_mute, volume,
		left_output_float, right_output_float};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	reset_defaults_a: assert property ($rose(rst_n) |-> sda_oe && outs == 15'h0300)
		else $error("outputs not at defaults after reset");
	line_low_only_a: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data drive changed with clock high");
	ack_hold_a: assert property ($rose(scl_in) && !sda_oe |=> !sda_oe [*8])
		else $error("low drive dropped in clock high");
	pd_clear_a: assert property (soft_powerdown
		|-> !left_amp_enable && !right_amp_enable)
		else $error("enables kept in powerdown");
	regs_on_bus_a: assert property ($changed(outs) |-> scl_in)
		else $error("outputs changed off a bus bit");
	stop_release_a: assert property (scl_in && $rose(sda_in) |=> sda_oe [*8])
		else $error("data driven after stop");
	start_release_a: assert property (scl_in && $fell(sda_in) |-> sda_oe)
		else $error("data driven at start");
endmodule

// ---- tb/hpa_ctrl_tb_top.sv ----
`timescale 1ns/10ps
bind hpa_ctrl hpa_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.left_amp_enable(left_amp_enable), .right_amp_enable(right_amp_enable),
	.output_mode(output_mode), .soft_powerdown(soft_powerdown),
	.left_mute(left_mute), .right_mute(right_mute), .volume(volume),
	.left_output_float(left_output_float),
	.right_output_float(right_output_float));
module hpa_ctrl_tb_top;
	import hpa_pkg::*;
	localparam logic [3:0] REV = 4'h5;	// arbitrary revision
	localparam logic [7:0] WA = {HPA_SLAVE_ADDR, 1'b0};
	logic        clk, rst_n, thermal, scl, sda_m, sda_out, sda_oe;
	logic        ack_stb, ack_bit, byte_stb;
	logic [7:0]  ft, rd_byte, c, v, z;
	wire logic [14:0] outs;	// register outputs
	logic [7:0]  d [3];	// bytes to write
	logic [7:0]  e [8];	// bytes expected back
	logic        ea [$];	// ack notes
	logic [7:0]  eb [$];	// read byte notes
	int          error_cnt = 0;
	int          checks_done = 0;
	// wired-and data line with pull-up
	wire logic   sda = sda_m & (sda_oe | sda_out);
	hpa_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m),
		.ack_stb(ack_stb), .ack_bit(ack_bit), .byte_stb(byte_stb),
		.rd_byte(rd_byte));
	hpa_ctrl #(.REVISION(REV)) DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.thermal_event(thermal), .factory_test_bits(ft),
		.left_amp_enable(outs[14]), .right_amp_enable(outs[13]),
		.output_mode(outs[12:11]), .soft_powerdown(outs[10]),
		.left_mute(outs[9]), .right_mute(outs[8]), .volume(outs[7:2]),
		.left_output_float(outs[1]), .right_output_float(outs[0]));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic end_sim();
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp_out(input logic [14:0] g, x);
		checks_done++;
		if (g !== x) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic cmp_ack(input logic g, x);
		cmp_out({14'h0, g}, {14'h0, x});
	endtask
	task automatic cmp_byte(input logic [7:0] g, x);
		cmp_out({7'h0, g}, {7'h0, x});
	endtask
	// expected outputs from register contents
	function automatic logic [14:0] exp_o(input logic [7:0] c, v, z);
		return {c[7:6] & ~{2{c[0]}}, c[5:4], c[0], v, z[1:0]};
	endfunction
	// results are compared as they appear
	always @(posedge ack_stb) cmp_ack(ack_bit, ea.pop_front());
	always @(posedge byte_stb) cmp_byte(rd_byte, eb.pop_front());
	// start, address and register bytes
	task automatic hdr(input logic [7:0] a, r);
		logic x;
		x = a[7:1] != HPA_SLAVE_ADDR;
		m.start();
		ea.push_back(x);
		m.wr(a);
		ea.push_back(x);
		m.wr(r);
	endtask
	task automatic wseq(input logic [7:0] a, r, input int n);
		hdr(a, r);
		for (int i = 0; i < n; i++) begin
			ea.push_back(a[7:1] != HPA_SLAVE_ADDR);
			m.wr(d[i]);
		end
		m.stop();
	endtask
	task automatic rseq(input logic [7:0] r, input int n);
		hdr(WA, r);
		m.start();
		ea.push_back(1'b0);
		m.wr(WA | 8'h01);
		for (int i = 0; i < n; i++) begin
			eb.push_back(e[i]);
			m.rd(i == n - 1);
		end
		m.stop();
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		thermal = 1'b0;
		void'($urandom(32'hBA06));
		ft = 8'($urandom);
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (8) @(posedge clk);
		cmp_out(outs, exp_o(8'h00, 8'hC0, 8'h00));
		e = '{8'h00, 8'hC0, 8'h00, {2'b00, ft[5:4], REV}, ft, ft, ft, ft};
		rseq(8'h01, 8);
		for (int k = 0; k < 3; k++) begin
			c = {2'b11, 2'(k), 4'hE};
			v = 8'($urandom);
			z = 8'($urandom);
			d = '{c, v, z};
			wseq(WA, 8'h01, 3);
			cmp_out(outs, exp_o(c, v, z));
			c = c & 8'hF1;
			e[0] = c;
			e[1] = v;
			e[2] = z & 8'h03;
			rseq(8'h01, 3);
		end
		c = 8'hD1;
		d[0] = c;
		wseq(WA, 8'h01, 1);
		cmp_out(outs, exp_o(c, v, z));
		c = 8'h11;
		e[0] = c;
		rseq(8'h01, 1);
		d[0] = 8'h80;
		wseq(8'hC2, 8'h01, 1);
		cmp_out(outs, exp_o(c, v, z));
		v = 8'($urandom);
		d = '{8'h55, 8'h80, v};
		wseq(WA, 8'h00, 3);
		c = 8'h80;
		cmp_out(outs, exp_o(c, v, z));
		wseq(WA, 8'h09, 1);
		e[0] = {2'b00, ft[5:4], REV};
		rseq(8'h04, 1);
		@(posedge clk);
		#1 thermal = 1'b1;
		repeat (4) @(posedge clk);
		#1 thermal = 1'b0;
		e[0] = 8'h82;
		rseq(8'h01, 1);
		e[0] = 8'h80;
		rseq(8'h01, 1);
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk);
		#1 cmp_out(outs, exp_o(8'h00, 8'hC0, 8'h00));
		end_sim();
	end
endmodule
